// ==== rtl/supply_reset_pkg.sv ====
// constants, register layout and state encoding shared by the reset sequencer
package supply_reset_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned COUNT_W = 20;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_RESET_SOURCE = 8'hEF;
    localparam logic [7:0] IDX_SUPPLY_CONTROL = 8'hFF;
    localparam logic [ADDR_W-1:0] ADDR_RESET_SOURCE = {2'h0, IDX_RESET_SOURCE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SUPPLY_CONTROL = {2'h0, IDX_SUPPLY_CONTROL, 2'h0};

    // supply_monitor_control fields
    localparam int unsigned BIT_MON_ENABLE = 7;
    localparam int unsigned BIT_SUPPLY_STATUS = 6;
    localparam int unsigned BIT_THRESHOLD = 5;
    localparam int unsigned RESERVED_W = 5;
    // reset_source_register fields
    localparam int unsigned BIT_CLOCK_LOSS = 2;
    localparam int unsigned BIT_POWER_ON = 1;
    localparam int unsigned BIT_PIN = 0;

    localparam logic MON_ENABLE_RESET = 1'b1;
    localparam logic THRESHOLD_RESET = 1'b0;
    localparam logic MON_SELECT_RESET = 1'b1;
    localparam logic CLOCK_LOSS_ENABLE_RESET = 1'b0;
    localparam logic POWER_ON_FLAG_RESET = 1'b1;

    localparam int unsigned MCD_TIMEOUT_US = 100;
    localparam int unsigned MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_US * CLK_MHZ;
    localparam int unsigned POR_DELAY_US = 300;
    localparam int unsigned POR_DELAY_CYCLES = POR_DELAY_US * CLK_MHZ;
    localparam logic [1:0] PIN_BLANK_CYCLES = 2'h3;

    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_POR_WAIT = 6'h02,
        ST_SUPPLY = 6'h04,
        ST_PIN = 6'h08,
        ST_CLOCK = 6'h10,
        ST_FLASH = 6'h20
    } reset_state_t;
endpackage

// ==== rtl/clock_loss_detector.sv ====
// retriggerable one-shot that flags a stalled monitored clock
`timescale 1ns/10ps
`default_nettype none
module clock_loss_detector
    import supply_reset_pkg::*;
#(
    parameter logic [COUNT_W-1:0] TIMEOUT = COUNT_W'(MCD_TIMEOUT_CYCLES)
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic monitored_clock,
    output logic timed_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [COUNT_W-1:0] count;
    } det_state_t;

    det_state_t r;
    det_state_t next_r;
    logic edge_seen;

    // monitored clock must stay below half of CLK or edges are missed
    assign edge_seen = r.s2 ^ r.s3;
    assign timed_out = enable && (r.count == TIMEOUT);

    always_comb begin
        next_r = r;
        next_r.s1 = monitored_clock;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (!enable || edge_seen) begin
            next_r.count = '0;
        end else if (r.count != TIMEOUT) begin
            next_r.count = r.count + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    a_edge_rearms: assert property (@(posedge clk) disable iff (!resetn)
        (enable && edge_seen) |=> (r.count == '0))
        else $error("one-shot not retriggered by a clock edge");
    c_timeout: cover property (@(posedge clk) disable iff (!resetn) timed_out);
endmodule
`default_nettype wire

// ==== rtl/supply_pin_clockloss_reset.sv ====
// reset sequencer for supply monitor, external reset pin and clock-loss detector
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module supply_pin_clockloss_reset
    import supply_reset_pkg::*;
#(
    parameter logic [COUNT_W-1:0] MCD_TIMEOUT = COUNT_W'(MCD_TIMEOUT_CYCLES),
    parameter logic [COUNT_W-1:0] POR_DELAY = COUNT_W'(POR_DELAY_CYCLES)
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SUPPLY_ABOVE_THRESHOLD,
    input wire logic EXTERNAL_RESET_PIN_N_IN,
    output logic EXTERNAL_RESET_PIN_N_OUT,
    output logic EXTERNAL_RESET_PIN_N_OE_N,
    input wire logic SYSTEM_CLOCK_MONITOR,
    input wire logic FLASH_WRITE_REQ,
    output logic CORE_RESET,
    output logic SUPPLY_MONITOR_ENABLE,
    output logic SUPPLY_THRESHOLD_SELECT,
    output logic FLASH_ERROR_RESET
);
    typedef struct packed {
        reset_state_t state;
        logic [COUNT_W-1:0] count;
        logic [1:0] blank;
        logic supply_s1;
        logic supply_s2;
        logic pin_s1;
        logic pin_s2;
        logic monitor_enable;
        logic threshold_select;
        logic monitor_select;
        logic clock_loss_enable;
        logic power_on_flag;
        logic pin_flag;
        logic clock_loss_flag;
        logic [31:0] rdata;
    } top_state_t;

    top_state_t r;
    top_state_t next_r;
    logic clock_lost;
    logic supply_fault;
    logic pin_asserted;
    logic drive_pin;
    logic setup_phase;
    logic access_phase;
    logic in_clock_reset;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == ADDR_RESET_SOURCE) || (a == ADDR_SUPPLY_CONTROL);
    endfunction

    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input top_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == ADDR_SUPPLY_CONTROL) begin
            w[BIT_MON_ENABLE] = s.monitor_enable;
            w[BIT_SUPPLY_STATUS] = s.supply_s2;
            w[BIT_THRESHOLD] = s.threshold_select;
        end else if (a == ADDR_RESET_SOURCE) begin
            w[BIT_CLOCK_LOSS] = s.clock_loss_flag;
            w[BIT_POWER_ON] = s.power_on_flag;
            w[BIT_PIN] = s.pin_flag;
        end
        read_word = w;
    endfunction

    clock_loss_detector #(
        .TIMEOUT(MCD_TIMEOUT)
    ) u_clock_loss (
        .clk(CLK),
        .resetn(RESETN),
        .enable(r.clock_loss_enable),
        .monitored_clock(SYSTEM_CLOCK_MONITOR),
        .timed_out(clock_lost)
    );

    assign setup_phase = PSEL && !PENABLE;
    assign access_phase = PSEL && PENABLE;
    assign supply_fault = r.monitor_enable && r.monitor_select && !r.supply_s2;
    // our own drive echoes back through the synchroniser, so the pin is blanked briefly
    assign pin_asserted = !r.pin_s2 && (r.blank == 2'h0);
    assign drive_pin = (r.state == ST_SUPPLY) || (r.state == ST_POR_WAIT);
    assign in_clock_reset = (r.state == ST_CLOCK);

    always_comb begin
        next_r = r;
        next_r.supply_s1 = SUPPLY_ABOVE_THRESHOLD;
        next_r.supply_s2 = r.supply_s1;
        next_r.pin_s1 = EXTERNAL_RESET_PIN_N_IN;
        next_r.pin_s2 = r.pin_s1;

        if (drive_pin) begin
            next_r.blank = PIN_BLANK_CYCLES;
        end else if (r.blank != 2'h0) begin
            next_r.blank = r.blank - 1'b1;
        end

        case (r.state)
            ST_RUN: begin
                if (pin_asserted) begin
                    next_r.state = ST_PIN;
                    next_r.power_on_flag = 1'b0;
                end else if (clock_lost) begin
                    next_r.state = ST_CLOCK;
                    next_r.power_on_flag = 1'b0;
                end else if (FLASH_WRITE_REQ && !r.monitor_enable) begin
                    next_r.state = ST_FLASH;
                    next_r.power_on_flag = 1'b0;
                end
            end
            ST_POR_WAIT: begin
                // the release delay only starts once the supply is good
                if (!r.supply_s2) begin
                    next_r.count = '0;
                end else if (r.count == POR_DELAY - 1'b1) begin
                    next_r.state = ST_RUN;
                    next_r.count = '0;
                end else begin
                    next_r.count = r.count + 1'b1;
                end
            end
            ST_SUPPLY: begin
                if (!supply_fault) begin
                    next_r.state = ST_RUN;
                    next_r.pin_flag = 1'b0;
                    next_r.clock_loss_flag = 1'b0;
                end
            end
            ST_PIN: begin
                if (r.pin_s2) begin
                    next_r.state = ST_RUN;
                    next_r.pin_flag = 1'b1;
                    next_r.clock_loss_flag = 1'b0;
                end
            end
            ST_CLOCK: begin
                if (!clock_lost) begin
                    next_r.state = ST_RUN;
                    next_r.pin_flag = 1'b0;
                    next_r.clock_loss_flag = 1'b1;
                end
            end
            ST_FLASH: begin
                next_r.state = ST_RUN;
                next_r.pin_flag = 1'b0;
                next_r.clock_loss_flag = 1'b0;
            end
            default: begin
                next_r.state = ST_POR_WAIT;
                next_r.count = '0;
            end
        endcase

        // a supply fault overrides a running pin, clock-loss or flash reset, but not the power-on wait
        if (supply_fault && (r.state != ST_POR_WAIT) && (r.state != ST_SUPPLY)) begin
            next_r.state = ST_SUPPLY;
            next_r.power_on_flag = 1'b0;
        end

        if (setup_phase && !PWRITE) begin
            next_r.rdata = read_word(PADDR, r);
        end

        if (access_phase && PWRITE) begin
            if (PADDR == ADDR_SUPPLY_CONTROL) begin
                // status and low reserved bits are not writable
                next_r.monitor_enable = PWDATA[BIT_MON_ENABLE];
                next_r.threshold_select = PWDATA[BIT_THRESHOLD];
            end else if (PADDR == ADDR_RESET_SOURCE) begin
                next_r.monitor_select = PWDATA[BIT_POWER_ON];
                next_r.clock_loss_enable = PWDATA[BIT_CLOCK_LOSS];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            r.state <= ST_POR_WAIT;
            r.count <= '0;
            r.blank <= PIN_BLANK_CYCLES;
            r.supply_s1 <= 1'b0;
            r.supply_s2 <= 1'b0;
            r.pin_s1 <= 1'b1;
            r.pin_s2 <= 1'b1;
            r.monitor_enable <= MON_ENABLE_RESET;
            r.threshold_select <= THRESHOLD_RESET;
            r.monitor_select <= MON_SELECT_RESET;
            r.clock_loss_enable <= CLOCK_LOSS_ENABLE_RESET;
            r.power_on_flag <= POWER_ON_FLAG_RESET;
            r.pin_flag <= 1'b0;
            r.clock_loss_flag <= 1'b0;
            r.rdata <= 32'h0000_0000;
        end else begin
            r <= next_r;
        end
    end

    assign PRDATA = r.rdata;
    assign PREADY = 1'b1;
    assign PSLVERR = access_phase && !reg_hit(PADDR);
    assign CORE_RESET = (r.state != ST_RUN);
    assign EXTERNAL_RESET_PIN_N_OUT = 1'b0;
    assign EXTERNAL_RESET_PIN_N_OE_N = !drive_pin;
    assign SUPPLY_MONITOR_ENABLE = r.monitor_enable;
    assign SUPPLY_THRESHOLD_SELECT = r.threshold_select;
    assign FLASH_ERROR_RESET = (r.state == ST_FLASH);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    a_supply_fault_entry: assert property (
        (r.state == ST_RUN && supply_fault) |=>
        (r.state == ST_SUPPLY && CORE_RESET && !EXTERNAL_RESET_PIN_N_OE_N))
        else $error("supply fault did not enter driven reset");
    a_supply_release_fast: assert property (
        (r.state == ST_SUPPLY && !supply_fault) |=> !CORE_RESET)
        else $error("supply reset not released at once");
    a_monitor_kept: assert property (
        (r.state != ST_POR_WAIT && !(access_phase && PWRITE)) |=> $stable(r.monitor_enable))
        else $error("monitor enable changed without a write");
    a_flash_error_pulse: assert property (
        (r.state == ST_RUN && !supply_fault && !pin_asserted && !clock_lost
         && FLASH_WRITE_REQ && !r.monitor_enable) |=> FLASH_ERROR_RESET ##1 !FLASH_ERROR_RESET)
        else $error("flash error reset not one cycle");
    a_unselected_quiet: assert property (
        !r.monitor_select |=> (r.state != ST_SUPPLY))
        else $error("unselected monitor caused reset");
    a_pin_flag_exit: assert property (
        (r.state == ST_PIN && r.pin_s2 && !supply_fault) |=> (r.state == ST_RUN && r.pin_flag))
        else $error("pin flag not set on exit");
    a_clock_loss_entry: assert property (
        (r.state == ST_RUN && clock_lost && !supply_fault && !pin_asserted) |=>
        (r.state == ST_CLOCK))
        else $error("clock loss did not reset");
    a_clock_flag_cause: assert property (
        $fell(CORE_RESET) |-> (r.clock_loss_flag == $past(in_clock_reset)))
        else $error("clock-loss flag wrong after reset");
    a_clock_pin_free: assert property (
        in_clock_reset |-> EXTERNAL_RESET_PIN_N_OE_N)
        else $error("pin driven during clock-loss reset");
    a_por_flag_cleared: assert property (
        (r.state inside {ST_SUPPLY, ST_PIN, ST_CLOCK, ST_FLASH}) |-> !r.power_on_flag)
        else $error("power-on flag kept by other reset");
    a_status_readback: assert property (
        (setup_phase && !PWRITE && PADDR == ADDR_SUPPLY_CONTROL) |=>
        (PRDATA[BIT_SUPPLY_STATUS] == $past(r.supply_s2) && PRDATA[4:0] == 5'h00))
        else $error("control readback wrong");
    a_source_write: assert property (
        (access_phase && PWRITE && PADDR == ADDR_RESET_SOURCE) |=>
        (r.monitor_select == $past(PWDATA[1]) && r.clock_loss_enable == $past(PWDATA[2])))
        else $error("reset source write not taken");
    a_supply_core_held: assert property (
        (r.state == ST_SUPPLY) |-> (CORE_RESET && !EXTERNAL_RESET_PIN_N_OE_N))
        else $error("core free or pin released during supply reset");
    a_supply_override: assert property (
        (supply_fault && (r.state inside {ST_PIN, ST_CLOCK, ST_FLASH})) |=>
        (r.state == ST_SUPPLY))
        else $error("supply fault did not override running reset");
    a_por_held: assert property (
        (r.state == ST_POR_WAIT && !r.supply_s2) |=> (r.state == ST_POR_WAIT))
        else $error("power-on release before supply good");
    a_por_delay_counted: assert property (
        (r.state == ST_POR_WAIT && r.count != POR_DELAY - 1'b1) |=> CORE_RESET)
        else $error("power-on delay cut short");
    a_select_kept: assert property (
        (r.state != ST_POR_WAIT && !(access_phase && PWRITE && PADDR == ADDR_RESET_SOURCE))
        |=> $stable(r.monitor_select))
        else $error("monitor select changed without a write");
    a_flash_needs_off: assert property (
        FLASH_ERROR_RESET |-> ($past(FLASH_WRITE_REQ) && !$past(r.monitor_enable)))
        else $error("flash error reset without a flash write on a disabled monitor");
    a_flash_no_pin: assert property (
        FLASH_ERROR_RESET |-> (CORE_RESET && EXTERNAL_RESET_PIN_N_OE_N))
        else $error("flash error reset drove the pin or freed the core");
    a_enabled_no_flash: assert property (
        r.monitor_enable |=> !FLASH_ERROR_RESET)
        else $error("flash error reset with monitor enabled");
    a_disabled_quiet: assert property (
        !r.monitor_enable |=> (r.state != ST_SUPPLY))
        else $error("disabled monitor caused reset");
    a_pin_entry: assert property (
        (r.state == ST_RUN && pin_asserted && !supply_fault) |=>
        (r.state == ST_PIN && CORE_RESET))
        else $error("low reset pin did not reset");
    a_pin_blanked: assert property (
        (r.state == ST_RUN && r.blank != 2'h0) |=> (r.state != ST_PIN))
        else $error("own pin drive taken as external reset");
    a_pin_undriven: assert property (
        (r.state == ST_PIN) |-> EXTERNAL_RESET_PIN_N_OE_N)
        else $error("pin driven during external reset");
    a_clock_exit: assert property (
        (in_clock_reset && !clock_lost && !supply_fault) |=>
        (r.state == ST_RUN && r.clock_loss_flag))
        else $error("clock-loss reset exit wrong");
    a_detector_off: assert property (
        !r.clock_loss_enable |=> (r.state != ST_CLOCK))
        else $error("disabled detector caused reset");
    a_control_write: assert property (
        (access_phase && PWRITE && PADDR == ADDR_SUPPLY_CONTROL) |=>
        (r.monitor_enable == $past(PWDATA[BIT_MON_ENABLE])
         && r.threshold_select == $past(PWDATA[BIT_THRESHOLD])))
        else $error("control write not taken");

    c_supply_reset: cover property (r.state == ST_RUN ##1 r.state == ST_SUPPLY);
    c_pin_reset: cover property (r.state == ST_PIN ##1 r.state == ST_RUN);
    c_clock_reset: cover property (r.state == ST_CLOCK ##1 r.state == ST_RUN);
    c_por_done: cover property (r.state == ST_POR_WAIT ##1 r.state == ST_RUN);
endmodule
`default_nettype wire

// ==== test/ext_reset_driver.sv ====
// model of the external reset circuitry on the open-drain reset pin
`timescale 1ns/10ps
`default_nettype none
module ext_reset_driver (
    input wire logic clk,
    input wire logic assert_low,
    input wire logic dev_out,
    input wire logic dev_oe_n,
    output logic pin_level
);
    logic hold = 1'b0;
    always_ff @(posedge clk) begin
        hold <= assert_low;
    end
    // pull-up wins whenever neither party pulls the pin down
    assign pin_level = (hold || (!dev_oe_n && !dev_out)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== test/supply_pin_clockloss_reset_tb_top.sv ====
// self-checking bench for the supply, pin and clock-loss reset sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module supply_pin_clockloss_reset_tb_top;
    import supply_reset_pkg::*;
    logic clk, resetn, psel, penable, pwrite, supply, flash_req, mon_clk, mon_run, ext_low;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, perr, pin_out, pin_oe_n, pin_level, core_rst, mon_en, thr_sel;
    logic flash_err, seen;
    logic [2:0] mcnt = 3'h0;
    int n_fail = 0;
    int num_checks = 0;

    supply_pin_clockloss_reset #(.MCD_TIMEOUT(COUNT_W'(20)), .POR_DELAY(COUNT_W'(40))) i_dut (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SUPPLY_ABOVE_THRESHOLD(supply), .EXTERNAL_RESET_PIN_N_IN(pin_level),
        .EXTERNAL_RESET_PIN_N_OUT(pin_out), .EXTERNAL_RESET_PIN_N_OE_N(pin_oe_n),
        .SYSTEM_CLOCK_MONITOR(mon_clk), .FLASH_WRITE_REQ(flash_req), .CORE_RESET(core_rst),
        .SUPPLY_MONITOR_ENABLE(mon_en), .SUPPLY_THRESHOLD_SELECT(thr_sel),
        .FLASH_ERROR_RESET(flash_err));

    ext_reset_driver i_ext (.clk(clk), .assert_low(ext_low), .dev_out(pin_out),
        .dev_oe_n(pin_oe_n), .pin_level(pin_level));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // monitored clock toggles every 8 cycles, well below half the sampling rate
    always @(posedge clk) begin
        mcnt <= mcnt + 3'h1;
        if (mon_run && mcnt == 3'h7) begin
            mon_clk <= !mon_clk;
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        ok = (pready === 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // an idle edge keeps a following call from reassigning psel in this time step
        @(posedge clk);
        if (!ok) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task automatic wait_core(input logic v, input int lim);
        int n;
        n = 0;
        while (core_rst !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (core_rst !== v) begin
            n_fail++;
            $display("Error t=%0t core reset got=%h exp=%h", $time, core_rst, v);
            report_and_stop();
        end
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        supply = 1'b1;
        flash_req = 1'b0;
        mon_clk = 1'b0;
        mon_run = 1'b1;
        ext_low = 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        wait_core(1'b0, 100);
        apb(1'b0, ADDR_SUPPLY_CONTROL, 32'h0);
        `CHK(rd, 32'h000000C0)
        apb(1'b0, ADDR_RESET_SOURCE, 32'h0);
        `CHK(rd[1], 1'b1)
        apb(1'b1, ADDR_SUPPLY_CONTROL, 32'h000000BF);
        apb(1'b0, ADDR_SUPPLY_CONTROL, 32'h0);
        `CHK(rd, 32'h000000E0)
        `CHK(thr_sel, 1'b1)
        // supply fault with monitor enabled and selected since power-on
        supply <= 1'b0;
        wait_core(1'b1, 10);
        `CHK(pin_level, 1'b0)
        apb(1'b0, ADDR_SUPPLY_CONTROL, 32'h0);
        `CHK(rd[6], 1'b0)
        supply <= 1'b1;
        wait_core(1'b0, 8);
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR_RESET_SOURCE, 32'h0);
        `CHK(rd[2:0], 3'h0)
        // external pin reset
        ext_low <= 1'b1;
        wait_core(1'b1, 10);
        `CHK(pin_oe_n, 1'b1)
        repeat (5) @(posedge clk);
        ext_low <= 1'b0;
        wait_core(1'b0, 10);
        apb(1'b0, ADDR_RESET_SOURCE, 32'h0);
        `CHK(rd[2:0], 3'h1)
        // clock loss
        apb(1'b1, ADDR_RESET_SOURCE, 32'h00000006);
        mon_run <= 1'b0;
        wait_core(1'b1, 60);
        `CHK(pin_oe_n, 1'b1)
        mon_run <= 1'b1;
        wait_core(1'b0, 40);
        apb(1'b0, ADDR_RESET_SOURCE, 32'h0);
        `CHK(rd[2:0], 3'h4)
        apb(1'b1, ADDR_RESET_SOURCE, 32'h00000002);
        mon_run <= 1'b0;
        repeat (60) @(posedge clk);
        `CHK(core_rst, 1'b0)
        mon_run <= 1'b1;
        // monitor deselected, then selected again
        apb(1'b1, ADDR_RESET_SOURCE, 32'h0);
        supply <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK(core_rst, 1'b0)
        supply <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b1, ADDR_RESET_SOURCE, 32'h00000002);
        supply <= 1'b0;
        wait_core(1'b1, 10);
        supply <= 1'b1;
        wait_core(1'b0, 10);
        repeat (4) @(posedge clk);
        // flash write while monitor disabled
        apb(1'b1, ADDR_SUPPLY_CONTROL, 32'h0);
        `CHK(mon_en, 1'b0)
        flash_req <= 1'b1;
        @(posedge clk);
        flash_req <= 1'b0;
        seen = 1'b0;
        repeat (6) begin
            @(posedge clk);
            if (flash_err === 1'b1) begin
                seen = 1'b1;
            end
        end
        `CHK(seen, 1'b1)
        wait_core(1'b0, 10);
        apb(1'b0, ADDR_SUPPLY_CONTROL, 32'h0);
        `CHK(rd[7], 1'b0)
        supply <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(core_rst, 1'b0)
        supply <= 1'b1;
        // monitor re-enabled at the high threshold, settled, then selected again
        apb(1'b1, ADDR_SUPPLY_CONTROL, 32'h000000A0);
        repeat (1250) @(posedge clk);
        `CHK(mon_en, 1'b1)
        `CHK(thr_sel, 1'b1)
        apb(1'b1, ADDR_RESET_SOURCE, 32'h00000002);
        supply <= 1'b0;
        wait_core(1'b1, 10);
        `CHK(pin_oe_n, 1'b0)
        supply <= 1'b1;
        wait_core(1'b0, 10);
        apb(1'b0, ADDR_RESET_SOURCE, 32'h0);
        `CHK(rd[2:0], 3'h0)
        // second power-on reset in mid-run restores the monitor defaults
        apb(1'b1, ADDR_SUPPLY_CONTROL, 32'h0);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        wait_core(1'b0, 100);
        apb(1'b0, ADDR_SUPPLY_CONTROL, 32'h0);
        `CHK(rd, 32'h000000C0)
        apb(1'b0, ADDR_RESET_SOURCE, 32'h0);
        `CHK(rd[1], 1'b1)
        // unmapped address
        apb(1'b0, 12'h010, 32'h0);
        `CHK(perr, 1'b1)
        `CHK(rd, 32'h0)
        report_and_stop();
    end
endmodule
`default_nettype wire
